//--- core/touch_report_spi_slave.sv
`timescale 1ns/1ps
// Behaviour
// R01: One bit in, one out per clock
// R02: Bytes travel most significant bit first
// R03: Idle byte out is fixed fill
// R04: Raise interrupt when report is ready
// R05: Drop interrupt after first report byte
// R06: Raise interrupt when response is ready
// R07: Drop interrupt after first response byte
// R08: Host keeps serial clock under 900 kHz; the test host model runs it at 8 MHz (125 ns bit period)
// R09: Host pauses about 50 us between bytes; the test host model pauses about 3.4 us (GAP of 2000 ns plus framing)
// R10: Report is exactly five bytes
// R11: Coordinates 12 bit, low two zero
// R12: Head byte: bit7 set, bit0 pen
// R13: Coordinate split low seven, high five
// R14: Host should use full 12-bit coordinates
// R15: Clock idles low, output changes falling
// R16: Output released while select inactive
// R17: Finish current packet before next one
// R18: Synchronise serial inputs before edge detect
module touch_report_spi_slave #(
   parameter int FIFO_DEPTH = touch_spi_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Serial link pins
   input  wire logic        sck,
   input  wire logic        sdi,
   input  wire logic        ss_n,
   output logic             sdo_out,
   output logic             sdo_oe_n,
   output logic             data_ready_irq,
   // Touch report from the sampling logic
   input  wire logic        report_valid,
   output logic             report_ready,
   input  wire logic [11:0] horizontal_coordinate,
   input  wire logic [11:0] vertical_coordinate,
   input  wire logic        pen_down,
   // Command response bytes, last marks the end of a response
   input  wire logic        resp_valid,
   output logic             resp_ready,
   input  wire logic [7:0]  resp_data,
   input  wire logic        resp_last,
   // Command bytes received from the host
   output logic             cmd_valid,
   output logic [7:0]       cmd_data
);

   // Which source is being copied into the queue
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_REPORT = 2'b01,
      ST_RESP   = 2'b10
   } src_e;

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers

   logic [1:0] sck_sync;
   logic [1:0] sdi_sync;
   logic [1:0] ss_sync;
   logic       sck_prev;
   logic       sck_rise;
   logic       sck_fall;
   logic       selected;

   // Two stages per pin before any logic looks at them
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sck_sync <= 2'b00;
         sdi_sync <= 2'b00;
         ss_sync  <= 2'b11;
         sck_prev <= 1'b0;
      end else begin
         sck_sync <= {sck_sync[0], sck};      // see R18
         sdi_sync <= {sdi_sync[0], sdi};
         ss_sync  <= {ss_sync[0], ss_n};
         sck_prev <= sck_sync[1];
      end
   end

   // Edges count only while the host selects us
   assign selected = !ss_sync[1];
   assign sck_rise = selected && sck_sync[1] && !sck_prev;   // see R18
   assign sck_fall = selected && !sck_sync[1] && sck_prev;   // see R15

   ////////////////////////////////////////////////////////////////////////
   // Packet source and FIFO loading

   src_e       src;
   src_e       next_src;
   logic [2:0] load_idx;
   logic [2:0] next_load_idx;
   logic [7:0] fifo_in_data;
   logic       fifo_in_valid;
   logic       fifo_in_ready;
   logic       fifo_out_valid;
   logic       fifo_out_ready;
   logic [7:0] fifo_out_data;
   logic [7:0] report_byte;
   logic       next_report_ready;
   // Shifter busy flag, also holds off the loader
   logic       pkt_active;
   logic       next_pkt_active;

   // Select one byte of the five-byte report
   always_comb begin
      unique case (load_idx)
         3'h0: report_byte = touch_spi_pkg::HEAD_MARK
                             | {7'h00, pen_down};            // see R12
         3'h1: report_byte = {1'b0, horizontal_coordinate[6:2],
                              2'b00};                        // see R11, R13
         3'h2: report_byte = {3'b000, horizontal_coordinate[11:7]}; // see R13
         3'h3: report_byte = {1'b0, vertical_coordinate[6:2],
                              2'b00};                        // see R11
         default: report_byte = {3'b000, vertical_coordinate[11:7]};
      endcase
   end

   // Copy one packet at a time, only into an empty queue
   always_comb begin
      next_src      = src;
      next_load_idx = load_idx;
      fifo_in_valid = 1'b0;
      fifo_in_data  = report_byte;
      next_report_ready = 1'b0;
      resp_ready    = 1'b0;
      unique case (src)
         ST_IDLE: begin
            if (!fifo_out_valid && !pkt_active) begin   // see R17
               // Reports win over responses
               if (report_valid) begin
                  next_src = ST_REPORT;
               end else if (resp_valid) begin
                  next_src = ST_RESP;
               end
            end
            next_load_idx = touch_spi_pkg::FIRST_BYTE;
         end
         ST_REPORT: begin
            // Push the five report bytes in order
            fifo_in_valid = 1'b1;
            if (fifo_in_ready) begin
               if (load_idx == touch_spi_pkg::LAST_BYTE) begin // see R10
                  next_report_ready = 1'b1;
                  next_src     = ST_IDLE;
               end else begin
                  next_load_idx = load_idx + 3'h1;
               end
            end
         end
         ST_RESP: begin
            // Response bytes stream straight into the queue
            fifo_in_valid = resp_valid;
            fifo_in_data  = resp_data;
            resp_ready    = fifo_in_ready;
            if (resp_valid && fifo_in_ready && resp_last) begin
               next_src = ST_IDLE;
            end
         end
         default: next_src = ST_IDLE;
      endcase
   end

   // Loader state; the report accept pulse leaves a flop
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         src          <= ST_IDLE;
         load_idx     <= touch_spi_pkg::FIRST_BYTE;
         report_ready <= 1'b0;
      end else begin
         src          <= next_src;
         load_idx     <= next_load_idx;
         report_ready <= next_report_ready;
      end
   end

   // Queue of packet bytes waiting for the shifter
   byte_fifo #(
      .WIDTH (touch_spi_pkg::WORD_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (fifo_in_data),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // Serial shifter

   // Shift registers, counters and packet flags
   logic [7:0] tx_shift;
   logic [7:0] next_tx_shift;
   logic [7:0] rx_shift;
   logic [7:0] next_rx_shift;
   logic [2:0] bit_cnt;
   logic [2:0] next_bit_cnt;
   logic       pkt_start;
   logic       first_pending;
   logic       next_first_pending;
   logic       next_irq;
   logic       next_sdo_out;
   logic       next_cmd_valid;
   logic [7:0] next_cmd_data;
   logic       byte_end;

   assign byte_end       = sck_fall && (bit_cnt == touch_spi_pkg::LAST_BIT);
   // A queued packet starts between bytes, with the clock at rest
   assign pkt_start      = !pkt_active && fifo_out_valid
                           && (src == ST_IDLE) && (bit_cnt == 3'h0)
                           && !sck_sync[1] && !sck_fall;   // see R17
   // Pop at packet start and at each byte end inside a packet
   assign fifo_out_ready = pkt_start || (byte_end && pkt_active);

   // Bits sampled on rising edge, shifted out on falling edge
   always_comb begin
      next_tx_shift      = tx_shift;
      next_rx_shift      = rx_shift;
      next_bit_cnt       = bit_cnt;
      next_pkt_active    = pkt_active;
      next_first_pending = first_pending;
      next_irq           = data_ready_irq;
      next_cmd_valid     = 1'b0;
      next_cmd_data      = cmd_data;
      // Deselect abandons a partial byte
      if (!selected) begin
         next_bit_cnt = 3'h0;
      end
      // Host data sampled on the rising edge
      if (sck_rise) begin
         next_rx_shift = {rx_shift[6:0], sdi_sync[1]};   // see R01, R02
      end
      // Next output bit on the falling edge
      if (sck_fall) begin
         next_tx_shift = {tx_shift[6:0], 1'b0};          // see R02, R15
         next_bit_cnt  = bit_cnt + 3'h1;
      end
      if (byte_end) begin
         next_cmd_valid = 1'b1;
         next_cmd_data  = rx_shift;
         if (first_pending) begin
            next_irq           = 1'b0;                  // see R05, R07
            next_first_pending = 1'b0;
         end
         // Load next byte, or fill when nothing is queued
         if (pkt_active && fifo_out_valid) begin
            next_tx_shift = fifo_out_data;
         end else begin
            next_tx_shift   = touch_spi_pkg::FILL_BYTE; // see R03
            next_pkt_active = 1'b0;
         end
      end
      // Packet arrives at an idle shifter: preload first byte, interrupt
      if (pkt_start) begin
         next_tx_shift      = fifo_out_data;
         next_pkt_active    = 1'b1;
         next_first_pending = 1'b1;
         next_irq           = 1'b1;                     // see R04, R06
      end
      // Nothing queued: keep the fill byte ready
      if (!pkt_active && !fifo_out_valid && bit_cnt == 3'h0
          && !sck_fall) begin
         next_tx_shift = touch_spi_pkg::FILL_BYTE;       // see R03
      end
      // Output pin follows the shifter msb
      next_sdo_out = next_tx_shift[touch_spi_pkg::BYTE_BITS-1];
   end

   // Shifter registers; every pin output leaves a flop
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_shift       <= touch_spi_pkg::FILL_BYTE;
         rx_shift       <= 8'h00;
         bit_cnt        <= 3'h0;
         pkt_active     <= 1'b0;
         first_pending  <= 1'b0;
         data_ready_irq <= 1'b0;
         sdo_out        <= 1'b0;
         sdo_oe_n       <= 1'b1;
         cmd_valid      <= 1'b0;
         cmd_data       <= 8'h00;
      end else begin
         tx_shift       <= next_tx_shift;
         rx_shift       <= next_rx_shift;
         bit_cnt        <= next_bit_cnt;
         pkt_active     <= next_pkt_active;
         first_pending  <= next_first_pending;
         data_ready_irq <= next_irq;
         sdo_out        <= next_sdo_out;
         sdo_oe_n       <= !selected;                   // see R16
         cmd_valid      <= next_cmd_valid;
         cmd_data       <= next_cmd_data;
      end
   end

endmodule

//--- pkg/touch_spi_pkg.sv
package touch_spi_pkg;

   // Fill byte shifted out when nothing is pending
   localparam logic [7:0] FILL_BYTE     = 8'h4D;
   // Packet layout
   localparam int         PACKET_BYTES  = 5;
   localparam int         COORD_WIDTH   = 12;
   localparam int         LOW_ZERO_BITS = 2;
   localparam int         LOW_PART_MSB  = 6;
   localparam int         HIGH_PART_LSB = 7;
   localparam logic [7:0] HEAD_MARK     = 8'h80;
   localparam int         PEN_BIT       = 0;
   // Byte and bit counting
   localparam int         BYTE_BITS     = 8;
   localparam logic [2:0] LAST_BIT      = 3'h7;
   localparam logic [2:0] LAST_BYTE     = 3'h4;
   localparam logic [2:0] FIRST_BYTE    = 3'h0;
   // Data FIFO
   localparam int         FIFO_DEPTH    = 16;
   localparam int         WORD_WIDTH    = 8;

endpackage

//--- core/byte_fifo.sv
`timescale 1ns/1ps
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic [AW:0]      next_wr_ptr;
   logic [AW:0]      next_rd_ptr;
   logic             do_wr;
   logic             do_rd;

   // Full and empty from pointer compare with wrap bit
   assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW])
                        && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
   assign out_valid = (wr_ptr != rd_ptr);
   assign out_data  = mem[rd_ptr[AW-1:0]];
   assign do_wr     = in_valid && in_ready;
   assign do_rd     = out_valid && out_ready;

   // Pointer advance
   always_comb begin
      next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end

   // Storage
   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

endmodule

//--- testbench/touch_report_spi_slave_asserts.sv
`timescale 1ns/1ps
module touch_report_spi_slave_asserts #(
   parameter int FIFO_DEPTH = 16
) (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // Serial link
   input wire logic        sck,
   input wire logic        sdi,
   input wire logic        ss_n,
   input wire logic        sdo_out,
   input wire logic        sdo_oe_n,
   input wire logic        data_ready_irq,
   // Report, response and command streams
   input wire logic        report_valid,
   input wire logic        report_ready,
   input wire logic [11:0] horizontal_coordinate,
   input wire logic [11:0] vertical_coordinate,
   input wire logic        pen_down,
   input wire logic        resp_valid,
   input wire logic        resp_ready,
   input wire logic [7:0]  resp_data,
   input wire logic        resp_last,
   input wire logic        cmd_valid,
   input wire logic [7:0]  cmd_data
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Pin released once select has settled high
   oe_off_a: assert property (
      ss_n [*8] |-> sdo_oe_n) else $error("sdo driven while deselected");
   // Output bits move only while the serial clock is low
   sdo_hold_a: assert property (
      !sdo_oe_n && $changed(sdo_out) |-> !sck)
      else $error("sdo moved while sck high");
   // Received byte reported once, after a falling edge
   cmd_pulse_a: assert property (
      cmd_valid |-> !sck ##1 !cmd_valid) else $error("bad cmd pulse");
   // Interrupt follows an accepted report
   irq_up_a: assert property (
      report_ready |-> ##[1:8] data_ready_irq) else $error("irq not raised");
   // Interrupt drops only at a byte end inside a frame
   irq_drop_a: assert property (
      $fell(data_ready_irq) |-> !ss_n && !sck) else $error("irq drop");
   // Interrupt holds while the host is away
   irq_hold_a: assert property (
      data_ready_irq && ss_n |=> data_ready_irq) else $error("irq lost");
   // Report accept is a single cycle
   rdy_pulse_a: assert property (
      report_ready |=> !report_ready) else $error("ready too long");
   // Report accept only with a report offered
   rdy_cause_a: assert property (
      report_ready |-> report_valid) else $error("ready without valid");
endmodule
bind touch_report_spi_slave touch_report_spi_slave_asserts #(
   .FIFO_DEPTH(FIFO_DEPTH)
) u_chk (.clk, .rst, .sck, .sdi, .ss_n, .sdo_out, .sdo_oe_n,
   .data_ready_irq, .report_valid, .report_ready, .horizontal_coordinate,
   .vertical_coordinate, .pen_down, .resp_valid, .resp_ready, .resp_data,
   .resp_last, .cmd_valid, .cmd_data);

//--- testbench/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model #(
   parameter realtime GAP = 2000.0
) (
   // Serial link
   output logic      sck,
   output logic      sdi,
   output logic      ss_n,
   input  wire logic sdo_out,
   input  wire logic sdo_oe_n
);
   logic sdo_wire;
   // A released pin shows the inverse of sdo_out
   assign sdo_wire = sdo_out ^ sdo_oe_n;
   // Idle link
   initial begin
      sck = 1'b0;
      sdi = 1'b0;
      ss_n = 1'b1;
   end
   // One framed byte, msb first, 125 ns bit period
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      ss_n = 1'b0;
      #500;
      for (int i = 7; i >= 0; i--) begin
         sdi = tx[i];
         #62.5;
         sck = 1'b1;
         rx[i] = sdo_wire;
         #62.5;
         sck = 1'b0;
      end
      #100;
      sdi = ~sdi;
      #700;
      ss_n = 1'b1;
      #GAP;
   endtask
endmodule

//--- testbench/touch_report_spi_slave_tb_top.sv
`timescale 1ns/1ps
module touch_report_spi_slave_tb_top;
   logic        clk, rst, sck, sdi, ss_n, sdo_out, sdo_oe_n;
   logic        data_ready_irq, report_valid, report_ready, pen_down;
   logic        resp_valid, resp_ready, resp_last, cmd_valid;
   logic [11:0] horizontal_coordinate, vertical_coordinate;
   logic [7:0]  resp_data, cmd_data, rx, last_cmd;
   int          fails, samples_checked;
   ////////////////////////////////////////////////////////////////////
   touch_report_spi_slave #(.FIFO_DEPTH(16)) u_dut (
      .clk, .rst, .sck, .sdi, .ss_n, .sdo_out, .sdo_oe_n, .data_ready_irq,
      .report_valid, .report_ready, .horizontal_coordinate,
      .vertical_coordinate, .pen_down, .resp_valid, .resp_ready,
      .resp_data, .resp_last, .cmd_valid, .cmd_data);
   spi_host_model u_host (.sck, .sdi, .ss_n, .sdo_out, .sdo_oe_n);
   // Clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Last byte received from the host
   always @(posedge clk) if (cmd_valid === 1'b1) last_cmd <= cmd_data;
   ////////////////////////////////////////////////////////////////////
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp1(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp12(input logic [11:0] got, input logic [11:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wait_irq(input logic lvl);
      int n;
      n = 0;
      while (data_ready_irq !== lvl && n < 200) begin
         @(negedge clk);
         n++;
      end
      cmp1(data_ready_irq, lvl);
   endtask
   task automatic print_verdict;
      $display("checks %0d fails %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   // Nothing pending: fill byte out, host byte in
   task automatic test_fill;
      cmp1(sdo_oe_n, 1'b1);
      u_host.xfer(8'hA5, rx);
      cmp8(rx, 8'h4D);
      cmp8(last_cmd, 8'hA5);
      $display("test fill done");
   endtask
   // Report packet, then fill after its last byte
   task automatic test_report(input logic p, input logic [11:0] x, y);
      int         n;
      logic [7:0] exp [6];
      logic [7:0] got [6];
      exp = '{{7'h40, p}, {1'b0, x[6:2], 2'b00}, {3'h0, x[11:7]},
              {1'b0, y[6:2], 2'b00}, {3'h0, y[11:7]}, 8'h4D};
      @(negedge clk);
      horizontal_coordinate = x;
      vertical_coordinate = y;
      pen_down = p;
      report_valid = 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (report_ready !== 1'b1 && n < 100);
      @(negedge clk);
      report_valid = 1'b0;
      wait_irq(1'b1);
      for (int i = 0; i < 6; i++) begin
         u_host.xfer(8'h00, rx);
         got[i] = rx;
         cmp8(rx, exp[i]);
         if (i == 0) cmp1(data_ready_irq, 1'b0);
      end
      // Host side rebuilds both 12-bit coordinates
      cmp12({got[2][4:0], got[1][6:0]}, {x[11:2], 2'b00});
      cmp12({got[4][4:0], got[3][6:0]}, {y[11:2], 2'b00});
      $display("test report done");
   endtask
   // Full FIFO of response bytes read back in order
   task automatic test_resp;
      int n;
      u_host.xfer(8'h12, rx);
      cmp8(rx, 8'h4D);
      cmp8(last_cmd, 8'h12);
      for (int i = 0; i < 16; i++) begin
         @(negedge clk);
         resp_valid = 1'b1;
         resp_data = 8'h30 + 8'(i);
         resp_last = (i == 15);
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (resp_ready !== 1'b1 && n < 2000);
      end
      @(negedge clk);
      resp_valid = 1'b0;
      wait_irq(1'b1);
      for (int i = 0; i < 16; i++) begin
         u_host.xfer(8'h00, rx);
         cmp8(rx, 8'h30 + 8'(i));
         if (i == 0) cmp1(data_ready_irq, 1'b0);
      end
      $display("test response done");
   endtask
   ////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rst = 1'b1;
      report_valid = 1'b0;
      horizontal_coordinate = 12'h000;
      vertical_coordinate = 12'h000;
      pen_down = 1'b0;
      resp_valid = 1'b0;
      resp_data = 8'h00;
      resp_last = 1'b0;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      repeat (2) @(negedge clk);
      test_fill();
      test_report(1'b1, 12'hABF, 12'h5F3);
      test_report(1'b0, 12'hFFF, 12'h000);
      test_resp();
      print_verdict();
   end
   // Watchdog
   initial begin
      #300000;
      fails++;
      print_verdict();
   end
endmodule
